// ### inc/chmcs_defines.svh
`ifndef CHMCS_DEFINES_SVH
`define CHMCS_DEFINES_SVH
// Oscillator input mode encodings.
`define CHMCS_OSC_MODE_XTAL 2'h1
`define CHMCS_OSC_MODE_SE 2'h2
// Seven-bit slave addresses per interface strap pair.
`define CHMCS_ADDR_A_00 7'h48
`define CHMCS_ADDR_A_01 7'h49
`define CHMCS_ADDR_A_10 7'h4A
`define CHMCS_ADDR_B_00 7'h4C
`define CHMCS_ADDR_B_01 7'h4D
`define CHMCS_ADDR_B_10 7'h4E
`define CHMCS_ADDR_NONE 7'h00
// Interface strap codes.
`define CHMCS_IF_SPI 2'h3
// Strap status reset value.
`define CHMCS_STRAP_RST 5'h00
// Input clock count.
`define CHMCS_NUM_INPUTS 3
`endif

// ### inc/chmcs_pkg.sv
package chmcs_pkg;
   typedef struct packed {
      logic test;
      logic [1:0] iface;
      logic [1:0] autocfg;
   } chmcs_strap_t;
   typedef struct packed {
      logic [1:0] osc_input_mode_field;
      logic doubler_enable_bit;
      logic master_clock_source_bit;
      logic ring_osc_disable_bit;
   } chmcs_mcr_t;
   typedef enum logic [2:0] {
      CHMCS_SEL_RING = 3'h1,
      CHMCS_SEL_WAIT = 3'h2,
      CHMCS_SEL_EXT = 3'h4
   } chmcs_sel_t;
endpackage : chmcs_pkg

// ### rtl/chmcs_glitch_mux.sv
`timescale 1ns/1ps
// Glitch-free two-source clock switch: each leg is released only after the other has stopped.
module chmcs_glitch_mux (
   // Sources
   input wire logic clk_a_i,
   input wire logic clk_b_i,
   input wire logic nrst_i,
   // Select: 0 picks clk_a_i, 1 picks clk_b_i
   input wire logic sel_i,
   // Outputs
   output logic clk_o,
   output logic on_b_o
);
   logic a_s1_q;
   logic a_s2_q;
   logic a_en_q;
   logic b_s1_q;
   logic b_s2_q;
   logic b_en_q;
   logic a_req;
   logic b_req;
   assign a_req = ~sel_i & ~b_en_q;
   assign b_req = sel_i & ~a_en_q;
   always_ff @(posedge clk_a_i or negedge nrst_i) begin
      if (!nrst_i) begin
         a_s1_q <= 1'b1;
         a_s2_q <= 1'b1;
      end else begin
         a_s1_q <= a_req;
         a_s2_q <= a_s1_q;
      end
   end
   // Enable changes on the falling edge so the gated clock never shortens a high phase.
   always_ff @(negedge clk_a_i or negedge nrst_i) begin
      if (!nrst_i) begin
         a_en_q <= 1'b1;
      end else begin
         a_en_q <= a_s2_q;
      end
   end
   always_ff @(posedge clk_b_i or negedge nrst_i) begin
      if (!nrst_i) begin
         b_s1_q <= 1'b0;
         b_s2_q <= 1'b0;
      end else begin
         b_s1_q <= b_req;
         b_s2_q <= b_s1_q;
      end
   end
   always_ff @(negedge clk_b_i or negedge nrst_i) begin
      if (!nrst_i) begin
         b_en_q <= 1'b0;
      end else begin
         b_en_q <= b_s2_q;
      end
   end
   assign clk_o = (clk_a_i & a_en_q) | (clk_b_i & b_en_q);
   assign on_b_o = b_en_q;
endmodule : chmcs_glitch_mux

// ### rtl/chmcs_top.sv
`timescale 1ns/1ps
`include "chmcs_defines.svh"
// Functional notes
// - Straps 1,0 give address 1001010 on channel A, 1001110 on channel B.
// - Straps 0,1 give channel B address 1001101.
// - Mode 10 enables the oscillator pin as single-ended input, crystal pin unused.
// - Mode 01 enables the crystal driver across both oscillator pins.
// - Doubler bit inserts a times-two stage after the oscillator source.
// - After reset, registers and interface run from the ring oscillator.
// - Ring-oscillator disable bit powers the ring oscillator down once the master clock runs from the external source.
// - Each of three input clocks has its own enable bit.
// - Unused third input pin serves as general-purpose I/O.
// - Test, interface and autoconfig straps latch at reset release, read-only.
// - Two autoconfig straps select stored configuration 0 to 3.
// - Straps 0,0 give channel A address 1001000.
module chmcs_top
   import chmcs_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic NRST_I,
   // Channel identity: 0 channel A, 1 channel B
   input wire logic CHAN_B_I,
   // Strap pins, sampled on CLK_I through two flops
   input wire logic TEST_STRAP_I,
   input wire logic IFACE_STRAP_HIGH_I,
   input wire logic IFACE_STRAP_LOW_I,
   input wire logic AUTOCFG_STRAP_HIGH_I,
   input wire logic AUTOCFG_STRAP_LOW_I,
   // Master configuration register fields
   input wire chmcs_mcr_t MASTER_CONFIG_REG_ONE_I,
   input wire logic [2:0] INPUT_CLOCK_ENABLE_REG_I,
   // Oscillator sources
   input wire logic RING_OSC_CLK_I,
   input wire logic OSC_IN_PIN_I,
   input wire logic DOUBLED_OSC_I,
   // Extra general-purpose pin on the third input
   input wire logic EXTRA_GENERAL_IO_PIN_I,
   input wire logic EXTRA_IO_OUT_I,
   input wire logic EXTRA_IO_DIR_I,
   output logic EXTRA_GENERAL_IO_PIN_O,
   output logic EXTRA_GENERAL_IO_PIN_OE_O,
   output logic EXTRA_IO_IN_O,
   // Strap status and interface setup
   output chmcs_strap_t STRAP_CAPTURE_STATUS_REG_O,
   output logic I2C_MODE_O,
   output logic SPI_MODE_O,
   output logic [6:0] I2C_SLAVE_ADDR_O,
   output logic [1:0] AUTOCFG_SEL_O,
   // Analog controls
   output logic XTAL_DRV_EN_O,
   output logic SE_INPUT_EN_O,
   output logic DOUBLER_EN_O,
   output logic RING_OSC_PD_O,
   output logic [2:0] INPUT_CLK_EN_O,
   // Master clock
   output logic MASTER_CLK_O,
   output logic MASTER_ON_EXT_O
);
   logic [4:0] strap_s1_q;
   logic [4:0] strap_s2_q;
   logic captured_q;
   chmcs_strap_t strap_q;
   logic [6:0] addr_d;
   logic [6:0] addr_q;
   chmcs_sel_t sel_q;
   chmcs_sel_t sel_d;
   logic xtal_q;
   logic se_q;
   logic doubler_q;
   logic pd_q;
   logic pd_allowed;
   logic [2:0] in_clk_en_q;
   logic [1:0] mode;
   logic osc_src;
   logic ext_clk;
   logic mux_on_ext;
   logic gpio_s1_q;
   logic gpio_s2_q;
   logic chan_s1_q;
   logic chan_s2_q;
   logic fill1_q;
   logic fill2_q;
   logic ext_s1_q;
   logic ext_s2_q;

   function automatic logic [6:0] addr_of(input logic [1:0] ifc, input logic chb);
      logic [6:0] a;
      a = `CHMCS_ADDR_NONE;
      unique case (ifc)
         2'h0: a = chb ? `CHMCS_ADDR_B_00 : `CHMCS_ADDR_A_00;
         2'h1: a = chb ? `CHMCS_ADDR_B_01 : `CHMCS_ADDR_A_01;
         2'h2: a = chb ? `CHMCS_ADDR_B_10 : `CHMCS_ADDR_A_10;
         2'h3: a = `CHMCS_ADDR_NONE;
      endcase
      return a;
   endfunction : addr_of

   // Straps pass two flops; capture waits until the second stage holds real pin levels.
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         strap_s1_q <= `CHMCS_STRAP_RST;
         strap_s2_q <= `CHMCS_STRAP_RST;
         chan_s1_q <= 1'b0;
         chan_s2_q <= 1'b0;
         fill1_q <= 1'b0;
         fill2_q <= 1'b0;
         strap_q <= chmcs_strap_t'(`CHMCS_STRAP_RST);
         captured_q <= 1'b0;
         addr_q <= `CHMCS_ADDR_NONE;
      end else begin
         strap_s1_q <= {TEST_STRAP_I, IFACE_STRAP_HIGH_I, IFACE_STRAP_LOW_I,
                        AUTOCFG_STRAP_HIGH_I, AUTOCFG_STRAP_LOW_I};
         strap_s2_q <= strap_s1_q;
         chan_s1_q <= CHAN_B_I;
         chan_s2_q <= chan_s1_q;
         fill1_q <= 1'b1;
         fill2_q <= fill1_q;
         if (fill2_q && !captured_q) begin
            strap_q <= chmcs_strap_t'(strap_s2_q);
            addr_q <= addr_d;
            captured_q <= 1'b1;
         end
      end
   end
   assign addr_d = addr_of(strap_s2_q[3:2], chan_s2_q);

   assign STRAP_CAPTURE_STATUS_REG_O = strap_q;
   assign I2C_SLAVE_ADDR_O = addr_q;
   assign SPI_MODE_O = captured_q & (strap_q.iface == `CHMCS_IF_SPI);
   assign I2C_MODE_O = captured_q & (strap_q.iface != `CHMCS_IF_SPI);
   assign AUTOCFG_SEL_O = strap_q.autocfg;

   // Oscillator and input controls are registered so the analog enables never glitch.
   assign mode = MASTER_CONFIG_REG_ONE_I.osc_input_mode_field;
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         xtal_q <= 1'b0;
         se_q <= 1'b0;
         doubler_q <= 1'b0;
         pd_q <= 1'b0;
         in_clk_en_q <= 3'h0;
      end else begin
         xtal_q <= (mode == `CHMCS_OSC_MODE_XTAL);
         se_q <= (mode == `CHMCS_OSC_MODE_SE);
         doubler_q <= MASTER_CONFIG_REG_ONE_I.doubler_enable_bit;
         // Powering down while still on the ring would stall the logic, so it waits.
         pd_q <= MASTER_CONFIG_REG_ONE_I.ring_osc_disable_bit & pd_allowed;
         in_clk_en_q <= INPUT_CLOCK_ENABLE_REG_I;
      end
   end
   // The mux flag changes in the external clock domain, so it is synchronised first.
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
      end else begin
         ext_s1_q <= mux_on_ext;
         ext_s2_q <= ext_s1_q;
      end
   end
   // A request back to the ring wakes the ring at once, even with the disable bit still set.
   assign pd_allowed = ext_s2_q & (sel_q == CHMCS_SEL_EXT);
   assign XTAL_DRV_EN_O = xtal_q;
   assign SE_INPUT_EN_O = se_q;
   assign DOUBLER_EN_O = doubler_q;
   assign RING_OSC_PD_O = pd_q;
   assign INPUT_CLK_EN_O = in_clk_en_q;

   // External source: the doubler output replaces the raw pin when enabled.
   assign osc_src = doubler_q ? DOUBLED_OSC_I : OSC_IN_PIN_I;
   assign ext_clk = osc_src & (xtal_q | se_q);

   // Selection request state: ring after reset, external once software asks.
   always_comb begin
      sel_d = sel_q;
      unique case (sel_q)
         CHMCS_SEL_RING: if (MASTER_CONFIG_REG_ONE_I.master_clock_source_bit) begin
            sel_d = CHMCS_SEL_WAIT;
         end
         CHMCS_SEL_WAIT: begin
            if (!MASTER_CONFIG_REG_ONE_I.master_clock_source_bit) begin
               sel_d = CHMCS_SEL_RING;
            end else if (ext_s2_q) begin
               sel_d = CHMCS_SEL_EXT;
            end
         end
         CHMCS_SEL_EXT: if (!MASTER_CONFIG_REG_ONE_I.master_clock_source_bit) begin
            sel_d = CHMCS_SEL_RING;
         end
         default: sel_d = CHMCS_SEL_RING;
      endcase
   end
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         sel_q <= CHMCS_SEL_RING;
      end else begin
         sel_q <= sel_d;
      end
   end

   chmcs_glitch_mux u_mux (
      .clk_a_i(RING_OSC_CLK_I),
      .clk_b_i(ext_clk),
      .nrst_i(NRST_I),
      .sel_i(sel_q != CHMCS_SEL_RING),
      .clk_o(MASTER_CLK_O),
      .on_b_o(mux_on_ext)
   );
   assign MASTER_ON_EXT_O = (sel_q == CHMCS_SEL_EXT);

   // Third input pin doubles as general I/O while its clock enable is clear.
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         gpio_s1_q <= 1'b0;
         gpio_s2_q <= 1'b0;
      end else begin
         gpio_s1_q <= EXTRA_GENERAL_IO_PIN_I;
         gpio_s2_q <= gpio_s1_q;
      end
   end
   assign EXTRA_IO_IN_O = gpio_s2_q & ~in_clk_en_q[2];
   assign EXTRA_GENERAL_IO_PIN_O = EXTRA_IO_OUT_I;
   assign EXTRA_GENERAL_IO_PIN_OE_O = EXTRA_IO_DIR_I & ~in_clk_en_q[2];

   a_xtal_mode: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      (mode == `CHMCS_OSC_MODE_XTAL) |=> (XTAL_DRV_EN_O && !SE_INPUT_EN_O))
      else $error("Crystal mode did not enable the crystal driver alone.");
   a_se_mode: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      (mode == `CHMCS_OSC_MODE_SE) |=> (SE_INPUT_EN_O && !XTAL_DRV_EN_O))
      else $error("Single-ended mode did not enable the input alone.");
   a_other_mode: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      (mode[0] == mode[1]) |=> !(SE_INPUT_EN_O || XTAL_DRV_EN_O))
      else $error("Unused mode code enabled an oscillator input.");
   a_dbl_follow: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      $rose(MASTER_CONFIG_REG_ONE_I.doubler_enable_bit) |=> DOUBLER_EN_O)
      else $error("Doubler did not follow its enable bit.");
   a_ring_pd: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      RING_OSC_PD_O |-> $past(ext_s2_q))
      else $error("Ring oscillator powered down while still in use.");
   a_input_clock_enable_reg_follow: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      NRST_I |=> (INPUT_CLK_EN_O == $past(INPUT_CLOCK_ENABLE_REG_I)))
      else $error("Input clock enables did not follow their register.");
   a_strap_hold: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      captured_q |=> $stable(STRAP_CAPTURE_STATUS_REG_O))
      else $error("Strap status changed after capture.");
   a_addr_a10: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      (captured_q && strap_q.iface == 2'h2 && !CHAN_B_I) |-> I2C_SLAVE_ADDR_O == 7'h4A)
      else $error("Channel A address for strap 10 is wrong.");
   a_addr_b01: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      (captured_q && strap_q.iface == 2'h1 && CHAN_B_I) |-> I2C_SLAVE_ADDR_O == 7'h4D)
      else $error("Channel B address for strap 01 is wrong.");
   a_start_ring: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      !MASTER_CONFIG_REG_ONE_I.master_clock_source_bit |=> !MASTER_ON_EXT_O)
      else $error("Master clock left the ring oscillator without request.");
endmodule : chmcs_top

// ### verification/chmcs_osc_model.sv
`timescale 1ns/1ps
// Oscillator sources that stand outside the channel: ring cell, external oscillator, doubler.
module chmcs_osc_model (
   // Control from the channel
   input wire logic ring_pd_i,
   // Clock sources
   output logic ring_clk_o,
   output logic osc_clk_o,
   output logic doubled_clk_o
);
   initial ring_clk_o = 1'b0;
   initial osc_clk_o = 1'b0;
   initial doubled_clk_o = 1'b0;
   // A powered-down ring cell stops low, so a late switch shows up as a missing clock.
   always #1.5 ring_clk_o = ring_pd_i ? 1'b0 : ~ring_clk_o;
   // The oscillator runs off a round rate.
   always #5.5 osc_clk_o = ~osc_clk_o;
   always #2.75 doubled_clk_o = ~doubled_clk_o;
endmodule : chmcs_osc_model

// ### verification/testbench.sv
`timescale 1ns/1ps
`include "chmcs_defines.svh"
module testbench
   import chmcs_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic chan_b = 1'b0;
   logic [4:0] strap = 5'h00;
   // Software keeps the ring running everywhere but in the clock-switch scenario.
   chmcs_mcr_t mcr = '0;
   logic [2:0] in_en = 3'h0;
   logic g_out = 1'b0, g_dir = 1'b0, g_ext = 1'b0;
   logic ring, osc, dclk, pin_o, pin_oe, g_in, i2c, spi, xtal, se;
   logic doubler_on, ring_pd, mclk, on_ext;
   logic pin_w;
   logic [6:0] addr;
   logic [1:0] ac_sel;
   logic [2:0] clk_en;
   chmcs_strap_t status;
   int fails = 0;
   int samples_checked = 0;
   realtime last_edge = 0;
   assign pin_w = pin_oe ? pin_o : g_ext;
   always #2.5 clk = ~clk;
   chmcs_osc_model chmcs_osc_model_i (.ring_pd_i(ring_pd), .ring_clk_o(ring), .osc_clk_o(osc),
      .doubled_clk_o(dclk));
   chmcs_top chmcs_top_i (.CLK_I(clk), .NRST_I(rst_n), .CHAN_B_I(chan_b),
      .TEST_STRAP_I(strap[4]), .IFACE_STRAP_HIGH_I(strap[3]), .IFACE_STRAP_LOW_I(strap[2]),
      .AUTOCFG_STRAP_HIGH_I(strap[1]), .AUTOCFG_STRAP_LOW_I(strap[0]),
      .MASTER_CONFIG_REG_ONE_I(mcr), .INPUT_CLOCK_ENABLE_REG_I(in_en), .RING_OSC_CLK_I(ring),
      .OSC_IN_PIN_I(osc), .DOUBLED_OSC_I(dclk), .EXTRA_GENERAL_IO_PIN_I(pin_w),
      .EXTRA_IO_OUT_I(g_out), .EXTRA_IO_DIR_I(g_dir), .EXTRA_GENERAL_IO_PIN_O(pin_o),
      .EXTRA_GENERAL_IO_PIN_OE_O(pin_oe), .EXTRA_IO_IN_O(g_in),
      .STRAP_CAPTURE_STATUS_REG_O(status),
      .I2C_MODE_O(i2c), .SPI_MODE_O(spi), .I2C_SLAVE_ADDR_O(addr), .AUTOCFG_SEL_O(ac_sel),
      .XTAL_DRV_EN_O(xtal), .SE_INPUT_EN_O(se), .DOUBLER_EN_O(doubler_on),
      .RING_OSC_PD_O(ring_pd),
      .INPUT_CLK_EN_O(clk_en), .MASTER_CLK_O(mclk), .MASTER_ON_EXT_O(on_ext));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : check
   task automatic print_verdict();
      if (fails == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   // No phase of the master clock may be shorter than half a ring period.
   always @(mclk) begin
      if (rst_n && $realtime - last_edge < 1.4) begin
         fails++;
         $display("Error at %0t: short master clock phase", $time);
      end
      last_edge = $realtime;
   end
   task automatic do_reset(input logic c, input logic [4:0] s);
      @(posedge clk);
      rst_n <= 1'b0;
      chan_b <= c;
      strap <= s;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
   endtask : do_reset
   task automatic strap_scan();
      logic [4:0] s;
      logic [6:0] exp;
      for (int c = 0; c < 2; c++) begin
         for (int i = 0; i < 4; i++) begin
            s = {i[0], i[1:0], i[1:0] ^ 2'h1};
            exp = (i == 3) ? `CHMCS_ADDR_NONE : (c[0] ? `CHMCS_ADDR_B_00 : `CHMCS_ADDR_A_00) + 7'(i);
            do_reset(c[0], s);
            check(8'(status), 8'(s));
            check(8'(addr), 8'(exp));
            check(8'({i2c, spi}), (i == 3) ? 8'h01 : 8'h02);
            check(8'(ac_sel), 8'(s[1:0]));
            @(posedge clk);
            strap <= ~s;
            repeat (3) @(posedge clk);
            #1;
            check(8'({status, ac_sel}), 8'({s, s[1:0]}));
         end
      end
   endtask : strap_scan
   task automatic mode_scan();
      for (int m = 0; m < 8; m++) begin
         @(posedge clk);
         mcr.osc_input_mode_field <= m[1:0];
         mcr.doubler_enable_bit <= m[2];
         @(posedge clk);
         #1;
         check(8'(xtal), 8'(m[1:0] == `CHMCS_OSC_MODE_XTAL));
         check(8'(se), 8'(m[1:0] == `CHMCS_OSC_MODE_SE));
         check(8'(doubler_on), 8'(m[2]));
      end
      // The switch scenario expects the raw oscillator, so the doubler is left off.
      @(posedge clk);
      mcr <= '0;
   endtask : mode_scan
   task automatic io_scan();
      logic [3:0] v;
      for (int k = 0; k < 16; k++) begin
         v = k[3:0];
         @(posedge clk);
         in_en <= v[2:0];
         g_dir <= v[3];
         g_out <= v[0];
         g_ext <= v[1];
         repeat (4) @(posedge clk);
         #1;
         check(8'(clk_en), 8'(v[2:0]));
         check(8'({pin_oe, pin_o}), 8'({v[3] & ~v[2], v[0]}));
         check(8'(g_in), v[2] ? 8'h00 : 8'(v[3] ? v[0] : v[1]));
      end
   endtask : io_scan
   task automatic wait_ext(input logic lvl);
      int n;
      n = 0;
      while (on_ext !== lvl && n < 100) begin
         @(posedge clk);
         n++;
      end
      #1;
      check(8'(on_ext), 8'(lvl));
   endtask : wait_ext
   task automatic switch_scan();
      do_reset(1'b0, 5'h00);
      check(8'(on_ext), 8'h00);
      repeat (4) begin
         @(posedge ring);
         #0.5;
         check(8'(mclk), 8'h01);
      end
      @(posedge clk);
      mcr.osc_input_mode_field <= `CHMCS_OSC_MODE_SE;
      mcr.ring_osc_disable_bit <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      check(8'(ring_pd), 8'h00);
      @(posedge clk);
      mcr.master_clock_source_bit <= 1'b1;
      wait_ext(1'b1);
      repeat (3) @(posedge clk);
      #1;
      check(8'(ring_pd), 8'h01);
      repeat (4) begin
         @(posedge osc);
         #1;
         check(8'(mclk), 8'h01);
      end
      // Software moves back to the ring before it stops the external source.
      @(posedge clk);
      mcr.master_clock_source_bit <= 1'b0;
      mcr.ring_osc_disable_bit <= 1'b0;
      wait_ext(1'b0);
      repeat (20) @(posedge clk);
      #1;
      check(8'(ring_pd), 8'h00);
      repeat (4) begin
         @(posedge ring);
         #0.5;
         check(8'(mclk), 8'h01);
      end
      @(posedge clk);
      mcr <= '0;
   endtask : switch_scan
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      strap_scan();
      mode_scan();
      io_scan();
      switch_scan();
      print_verdict();
   end
   // The whole run takes well under 10 us; a hang is cut short here.
   initial begin
      #20000;
      fails++;
      print_verdict();
   end
endmodule : testbench
